// >>> hw/bmrs_pkg.sv
package bmrs_pkg;

  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned FLASH_RECOVER_US = 2000;
  localparam int unsigned FLASH_RECOVER_CYC =
    FLASH_RECOVER_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 24;

  localparam logic        SEL_SINGLE_CHIP  = 1'h1;
  localparam logic        SEL_SINGLE_BOOT  = 1'h0;
  localparam logic [1:0]  GEAR_DIV_1_1     = 2'h0;

  localparam int unsigned SYNC_W           = 3;
  localparam int unsigned SYNC_MID         = 1;
  localparam int unsigned SYNC_LAST        = 2;
  localparam logic [CNT_W-1:0] CNT_STEP    = 24'h00_0001;

  typedef enum logic [1:0] {
    BMRS_BOOT_NONE,
    BMRS_BOOT_FLASH,
    BMRS_BOOT_ROM
  } bmrs_src_t;

  typedef enum {
    BMRS_ST_RESET,
    BMRS_ST_RECOVER,
    BMRS_ST_RUN
  } bmrs_state_t;

endpackage : bmrs_pkg

// >>> hw/bmrs_top.sv
// Behaviour
// - Single-chip mode fetches from internal flash.
// - Single-boot mode executes from mask boot ROM.
// - Boot pin level at reset picks mode.
// - Clock gear is one-to-one after reset.
// - Flash unreadable about 2 ms after interrupt.
// - Flash unreadable while erasing or writing; busy gates reads only in the run state, not on the edge entering it.
`timescale 1ns/1ps
module bmrs_top
  import bmrs_pkg::*;
#(
  parameter int unsigned RECOVER_CYC = FLASH_RECOVER_CYC
) (
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RST_N,
  input  wire logic       i_CE,
  input  wire logic       i_PORT_H_BIT_ZERO,
  input  wire logic       i_FLASH_BUSY,
  output logic            o_BOOT_ROM_SEL,
  output logic            o_FETCH_EN,
  output logic            o_FLASH_READ_OK,
  output logic [1:0]      o_CLK_GEAR,
  output logic [1:0]      o_BOOT_SRC
);

  // Notes for users of this block:
  // - The boot-select pin passes three flops, and a new level is only
  //   trusted once the last two agree, so the reset low time must span
  //   at least four enabled edges for the mode to be read at all.
  // - The pin is ignored once reset is released; a board that moves it
  //   later changes nothing until the next reset.
  // - Busy is gathered over every edge of the reset. A single busy edge
  //   sends the start through the recovery wait, because an operation
  //   cut short may leave the array unreadable for a while.
  // - During the recovery wait neither fetch nor reads are granted, so
  //   the processor does not run code from a half-settled array.
  // - RECOVER_CYC must fit the recovery counter; the default matches the
  //   recovery time at the nominal clock and a bench may shorten it.
  // - While the clock enable is low nothing moves, not even reset, so
  //   the enable must be high for the whole reset low time.
  // - The clock gear output never leaves the one-to-one setting here;
  //   other settings belong to software once the core is running.

  // All state of the sequencer is this one record.
  typedef struct packed {
    logic [SYNC_W-1:0] pin_sync;
    logic              pin_level;
    logic              busy_at_reset;
    logic [CNT_W-1:0]  rec_cnt;
    bmrs_state_t       state;
    logic              rom_sel;
    logic              fetch_en;
    logic              read_ok;
    logic [1:0]        gear;
    bmrs_src_t         src;
  } bmrs_regs_t;

  bmrs_regs_t s_reg;
  bmrs_regs_t s_next;

  always_comb begin
    logic             pin_agree;
    logic             busy_seen;
    logic             rec_done;
    logic             pick_flash;
    bmrs_src_t        pick_src;
    logic             pick_rom;
    logic [CNT_W-1:0] rec_load;
    logic [1:0]       gear_keep;

    pin_agree  = 1'h0;
    busy_seen  = 1'h0;
    rec_done   = 1'h0;
    pick_flash = 1'h0;
    pick_src   = BMRS_BOOT_NONE;
    pick_rom   = 1'h0;
    rec_load   = '0;
    gear_keep  = GEAR_DIV_1_1;
    // Anything not named below keeps its value.
    s_next     = s_reg;

    // Three-flop synchroniser on the boot-select pin; the settled
    // level only moves when the last two stages agree.
    s_next.pin_sync = {s_reg.pin_sync[SYNC_MID:0], i_PORT_H_BIT_ZERO};
    pin_agree = (s_reg.pin_sync[SYNC_LAST] == s_reg.pin_sync[SYNC_MID]);
    if (pin_agree) begin
      s_next.pin_level = s_reg.pin_sync[SYNC_LAST];
    end

    // Start source as decoded from the settled pin level.
    pick_flash = (s_reg.pin_level == SEL_SINGLE_CHIP);
    if (pick_flash) begin
      pick_src = BMRS_BOOT_FLASH;
      pick_rom = 1'h0;
    end else begin
      pick_src = BMRS_BOOT_ROM;
      pick_rom = 1'h1;
    end

    // The first reset edge after a run starts the busy record afresh,
    // so a busy flash before this reset is not held against it.
    if (s_reg.state == BMRS_ST_RESET) begin
      busy_seen = s_reg.busy_at_reset | i_FLASH_BUSY;
    end else begin
      busy_seen = i_FLASH_BUSY;
    end

    // Recovery counts down from RECOVER_CYC - 1 to zero.
    rec_load  = CNT_W'(RECOVER_CYC) - CNT_STEP;
    rec_done  = (s_reg.rec_cnt == '0);
    gear_keep = GEAR_DIV_1_1;

    if (!I_RST_N) begin
      // Outputs fall back to their idle values while reset is held.
      s_next.busy_at_reset = busy_seen;
      s_next.rec_cnt       = '0;
      s_next.state         = BMRS_ST_RESET;
      s_next.rom_sel       = 1'h0;
      s_next.fetch_en      = 1'h0;
      s_next.read_ok       = 1'h0;
      s_next.gear          = gear_keep;
      s_next.src           = BMRS_BOOT_NONE;
    end else begin
      // The first enabled edge after release decides how to start.
      case (s_reg.state)
        BMRS_ST_RESET: begin
          // The decoded source is latched once, at release.
          s_next.src           = pick_src;
          s_next.rom_sel       = pick_rom;
          s_next.gear          = gear_keep;
          s_next.busy_at_reset = 1'h0;
          if (s_reg.busy_at_reset) begin
            // Reset cut into a flash operation: hold fetch and reads.
            s_next.rec_cnt  = rec_load;
            s_next.state    = BMRS_ST_RECOVER;
            s_next.fetch_en = 1'h0;
            s_next.read_ok  = 1'h0;
          end else begin
            s_next.rec_cnt  = '0;
            s_next.state    = BMRS_ST_RUN;
            s_next.fetch_en = 1'h1;
            s_next.read_ok  = 1'h1;
          end
        end

        BMRS_ST_RECOVER: begin
          // Mode stays latched while the flash settles.
          s_next.src           = s_reg.src;
          s_next.rom_sel       = s_reg.rom_sel;
          s_next.gear          = gear_keep;
          s_next.busy_at_reset = 1'h0;
          if (rec_done) begin
            s_next.rec_cnt  = '0;
            s_next.state    = BMRS_ST_RUN;
            s_next.fetch_en = 1'h1;
            s_next.read_ok  = 1'h1;
          end else begin
            s_next.rec_cnt  = s_reg.rec_cnt - CNT_STEP;
            s_next.state    = BMRS_ST_RECOVER;
            s_next.fetch_en = 1'h0;
            s_next.read_ok  = 1'h0;
          end
        end

        BMRS_ST_RUN: begin
          // Source and mapping stay put until the next reset.
          s_next.src           = s_reg.src;
          s_next.rom_sel       = s_reg.rom_sel;
          s_next.gear          = gear_keep;
          s_next.busy_at_reset = 1'h0;
          s_next.rec_cnt       = '0;
          s_next.state         = BMRS_ST_RUN;
          // Fetch stays granted until the next reset.
          s_next.fetch_en      = 1'h1;
          // The array cannot be read while it erases or programs.
          if (i_FLASH_BUSY) begin
            s_next.read_ok = 1'h0;
          end else begin
            s_next.read_ok = 1'h1;
          end
        end

        default: begin
          // An unknown state falls back to reset behaviour.
          s_next.src           = BMRS_BOOT_NONE;
          s_next.rom_sel       = 1'h0;
          s_next.gear          = gear_keep;
          s_next.busy_at_reset = 1'h0;
          s_next.rec_cnt       = '0;
          s_next.state         = BMRS_ST_RESET;
          s_next.fetch_en      = 1'h0;
          s_next.read_ok       = 1'h0;
        end
      endcase
    end
  end

  // A low clock enable freezes the whole record, reset included.
  always_ff @(posedge I_SYS_CLK) begin
    if (i_CE) begin
      s_reg <= s_next;
    end
  end

  // Every output is a field of the registered record.
  assign o_BOOT_ROM_SEL  = s_reg.rom_sel;
  assign o_FETCH_EN      = s_reg.fetch_en;
  assign o_FLASH_READ_OK = s_reg.read_ok;
  assign o_CLK_GEAR      = s_reg.gear;
  assign o_BOOT_SRC      = s_reg.src;

endmodule : bmrs_top

// >>> verification/bmrs_chk_asserts.sv
`timescale 1ns/1ps
module bmrs_chk
  import bmrs_pkg::*;
(
  input wire logic       I_SYS_CLK,
  input wire logic       I_RST_N,
  input wire logic       i_CE,
  input wire logic       i_PORT_H_BIT_ZERO,
  input wire logic       i_FLASH_BUSY,
  input wire logic       o_BOOT_ROM_SEL,
  input wire logic       o_FETCH_EN,
  input wire logic       o_FLASH_READ_OK,
  input wire logic [1:0] o_CLK_GEAR,
  input wire logic [1:0] o_BOOT_SRC
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  property p_gear;
    o_CLK_GEAR == GEAR_DIV_1_1;
  endproperty
  a_gear: assert property (p_gear)
    else $error("clock gear left the one to one setting");

  property p_map;
    o_BOOT_ROM_SEL == (o_BOOT_SRC == BMRS_BOOT_ROM);
  endproperty
  a_map: assert property (p_map)
    else $error("boot rom mapping disagrees with start source");

  property p_hold;
    (o_BOOT_SRC != BMRS_BOOT_NONE) |=> $stable(o_BOOT_SRC);
  endproperty
  a_hold: assert property (p_hold)
    else $error("start source changed outside reset");

  property p_busy;
    (i_FLASH_BUSY && i_CE) |=> !o_FLASH_READ_OK;
  endproperty
  a_busy: assert property (p_busy)
    else $error("flash readable while busy");

  property p_fetch_src;
    o_FETCH_EN |-> (o_BOOT_SRC != BMRS_BOOT_NONE);
  endproperty
  a_fetch_src: assert property (p_fetch_src)
    else $error("fetch granted with no start source");

  property p_read_fetch;
    o_FLASH_READ_OK |-> o_FETCH_EN;
  endproperty
  a_read_fetch: assert property (p_read_fetch)
    else $error("flash readable during recovery");

  property p_start;
    ($rose(I_RST_N) && i_CE) |=> (o_BOOT_SRC != BMRS_BOOT_NONE);
  endproperty
  a_start: assert property (p_start)
    else $error("no start source one edge after release");
endmodule : bmrs_chk
bind bmrs_top bmrs_chk u_chk (.*);

// >>> verification/bmrs_rst_src.sv
`timescale 1ns/1ps
module bmrs_rst_src (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic mode,
  input  int        cyc,
  output logic      rst_n = 1'h0,
  output logic      pin   = 1'h1
);
  // Power-on reset: 700 us of 10 ns cycles.
  localparam int POR_CYC = 70000;
  int n = POR_CYC;
  always @(negedge clk) begin
    if (go) begin
      n     <= cyc;
      rst_n <= 1'h0;
      pin   <= mode;
    end else if (n > 1) begin
      n <= n - 1;
    end else begin
      rst_n <= 1'h1;
      // Once released the pin wanders, so a late change must be ignored.
      pin   <= ~pin;
    end
  end
endmodule : bmrs_rst_src

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench import bmrs_pkg::*;;
  localparam int RC      = 20;
  localparam int RST_CYC = 12;
  localparam int OP_CYC  = 50;
  logic       clk = 1'h0;
  logic       bsy = 1'h0;
  logic       go  = 1'h0;
  logic       md  = 1'h1;
  logic       ce  = 1'h1;
  logic       rn;
  logic       pin;
  logic       rom;
  logic       fe;
  logic       rok;
  logic [1:0] gr;
  logic [1:0] src;
  int         fail_count = 0;
  int         cmp_count  = 0;
  int         cyc        = RST_CYC;
  initial begin
    forever #5 clk = ~clk;
  end
  bmrs_rst_src ps (.clk, .go, .mode(md), .cyc, .rst_n(rn), .pin);
  bmrs_top #(.RECOVER_CYC(RC)) dut (.I_SYS_CLK(clk), .I_RST_N(rn),
    .i_CE(ce), .i_PORT_H_BIT_ZERO(pin), .i_FLASH_BUSY(bsy),
    .o_BOOT_ROM_SEL(rom), .o_FETCH_EN(fe), .o_FLASH_READ_OK(rok),
    .o_CLK_GEAR(gr), .o_BOOT_SRC(src));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic t_boot(logic m, logic b);
    int s = -1, f = -1;
    md  = m;
    bsy = b;
    cyc = b ? OP_CYC : RST_CYC;
    @(negedge clk) go <= 1'h1;
    @(negedge clk) go <= 1'h0;
    @(negedge clk) wait (rn === 1'h1);
    bsy = 1'h0;
    for (int n = 0; n < 60; n++) begin
      @(negedge clk);
      if (s < 0 && src !== 2'h0) s = n;
      if (f < 0 && fe === 1'b1) f = n;
    end
    chk("src", m ? BMRS_BOOT_FLASH : BMRS_BOOT_ROM, src);
    chk("rom", !m, rom);
    chk("fetch", b ? RC : 0, f - s);
    chk("gear", GEAR_DIV_1_1, gr);
  endtask : t_boot
  task automatic t_read();
    bsy = 1'h1;
    repeat (2) @(negedge clk);
    chk("rok", 0, rok);
    bsy = 1'h0;
    repeat (2) @(negedge clk);
    chk("rok", 1, rok);
  endtask : t_read
  task automatic t_freeze();
    ce  = 1'h0;
    bsy = 1'h1;
    repeat (3) @(negedge clk);
    chk("rok_frozen", 1, rok);
    ce  = 1'h1;
    repeat (2) @(negedge clk);
    chk("rok_busy", 0, rok);
    bsy = 1'h0;
    repeat (2) @(negedge clk);
    chk("rok_free", 1, rok);
  endtask : t_freeze
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    wait (rn === 1'h1);
    @(negedge clk);
    t_boot(1'h1, 1'h0);
    t_boot(1'h0, 1'h0);
    t_boot(1'h1, 1'h1);
    t_boot(1'h0, 1'h1);
    t_read();
    t_freeze();
    print_verdict();
  end
  // Power-on reset takes 700 us; the scenarios add a few microseconds.
  initial begin
    #750us;
    fail_count++;
    print_verdict();
  end
endmodule : testbench
